// >>> hw/mwcl_master_wakeup.sv
// Master wake-up controller: settings copy, EEPROM load, slave wake-up
// Summary of operation
// - Reset all, release only master controller
// - Latch GPIOs, hold reset levels 1 ms
// - Copy NVM to volatile copy, then live
// - Host reaches volatile copy, never live settings
// - Lock field 10 or 01 means locked
// - Manual bit high plus lock: autonomous wake
// - Slave pages belong to slaves, not here
// - Config bit 5 picks three-wire SPI
// - Config bit 6 gives I2C address A2
// - Config bit 4 marks EEPROM available
// - Latched GPIO decoding off unless NVM enables
// - Latched GPIOs decoded with live settings
// - Default lock-loss and oscillator-loss outputs
// - Remaining GPIOs default to inputs
// - EEPROM and I2C pin: search EEPROM
// - Valid block overwrites volatile and live
// - Success: read-done, port mode from block
// - Failure: error, read-done, become I2C
// - Error status readable by register, GPIO
// - Failure keeps live settings, waits commands
// - Decide lock from live settings
// - Release slaves per master settings
// - Reference paths first, then slaves in order
// - Unlocked: stop in program command wait
// - Address FF holds and selects page
`timescale 1ns/1ps
module mwcl_master_wakeup
   import mwcl_pkg::*;
   #(parameter int HOLD_CYC = HOLD_CYCLES)
   (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Non-volatile memory read
   output logic [7:0] nvmAddr,
   input wire logic [7:0] nvmData,
   // Host serial register access
   input wire logic hostWr,
   input wire logic [7:0] hostAddr,
   input wire logic [7:0] hostWdata,
   output logic [7:0] hostRdata,
   output logic hostBusy,
   input wire logic hostPortSelectPin,
   output logic hostSpiMode,
   output logic spiThreeWire,
   output logic i2cAddrA2,
   // Live settings read by the chip
   input wire logic [7:0] liveAddr,
   output logic [7:0] liveData,
   // EEPROM reader link
   input wire logic eeClk,
   input wire logic eeValid,
   input wire logic [7:0] eeAddr,
   input wire logic [7:0] eeData,
   input wire logic eeLast,
   input wire logic eeNoBlock,
   output logic eeReady,
   output logic eeSearch,
   // GPIO pins
   input wire logic [NUM_GPIO-1:0] gpioIn,
   output logic [NUM_GPIO-1:0] gpioOut,
   output logic [NUM_GPIO-1:0] gpioOe,
   // Status and controls through GPIOs
   input wire logic [3:0] pllLockLossN,
   input wire logic oscClockLossN,
   output logic outputDisableN,
   output logic [1:0] loopChoice,
   output logic freqStepA,
   output logic freqStepB,
   output logic [2:0] gpInput,
   output logic [NUM_GPIO-1:0] gpioLatched,
   // Wake-up control
   output logic [NUM_SLAVES-1:0] slaveRstN,
   output logic refClkEn,
   output logic chipActive,
   output logic prgCmdWait,
   output logic eeReadDone,
   output logic [1:0] eeError
   );
   localparam int HW = $clog2(HOLD_CYC + 1);
   localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYC - 1);

   function automatic logic isLocked(input logic [7:0] lockByte);
      return (lockByte[1:0] == LOCK_PAT_A || lockByte[1:0] == LOCK_PAT_B)
         && lockByte[LOCK_MANUAL_N_BIT];
   endfunction : isLocked

   logic [7:0] vol [0:255];
   logic [7:0] live [0:255];

   mwcl_state_type state_ff, nxt_state;
   logic [7:0] cnt_ff, nxt_cnt, page_ff, nxt_page, sum_ff, nxt_sum;
   logic [1:0] phase_ff, nxt_phase, err_ff, nxt_err;
   logic [HW-1:0] holdCnt_ff, nxt_holdCnt;
   logic holdDone_ff, nxt_holdDone, eeStart_ff, nxt_eeStart;
   logic eeUsed_ff, nxt_eeUsed, done_ff, nxt_done, hdr_ff, nxt_hdr;
   logic spi_ff, nxt_spi, ref_ff, nxt_ref, eeDis_ff, nxt_eeDis;
   logic [NUM_SLAVES-1:0] slvN_ff, nxt_slvN;
   logic [7:0] ifCfg_ff, nxt_ifCfg, lock_ff, nxt_lock, slvEn_ff, nxt_slvEn;
   logic [7:0] rdata_ff, nxt_rdata;
   logic [NUM_GPIO-1:0] latch_ff, nxt_latch;
   logic volWe, liveWe, hostOk, cmdApply, cmdActive;
   logic [7:0] volWa, volWd;
   // Clock-domain crossing
   logic [NUM_GPIO-1:0] gpioS1_ff, gpioS2_ff;
   logic pinS1_ff, pinS2_ff, reqS1_ff, reqS2_ff, reqSeen_ff, ackTgl_ff;
   logic wordNew;
   logic lrstS1_ff, linkRst_ff, startS1_ff, startS2_ff;
   logic ackS1_ff, ackS2_ff, reqTgl_ff, busy_ff, nxt_reqTgl;
   logic [7:0] wAddr_ff, wData_ff, nxt_wAddr, nxt_wData;
   logic wLast_ff, wNone_ff, nxt_wLast, nxt_wNone;

   // Master-side synchronisers
   always_ff @(posedge clk)
   begin
      gpioS1_ff <= gpioIn;
      gpioS2_ff <= gpioS1_ff;
      pinS1_ff <= hostPortSelectPin;
      pinS2_ff <= pinS1_ff;
      reqS1_ff <= reqTgl_ff;
      reqS2_ff <= reqS1_ff;
   end

   assign wordNew = reqS2_ff != reqSeen_ff;
   assign hostBusy = state_ff inside {ST_LATCH, ST_NVM, ST_APPLY, ST_EE};
   assign hostOk = hostWr && !hostBusy;
   // Slave pages are decoded by the slaves themselves
   assign cmdApply = hostOk && page_ff == PAGE_MASTER
      && hostAddr == REG_CMD && hostWdata == CMD_APPLY;
   assign cmdActive = hostOk && page_ff == PAGE_MASTER
      && hostAddr == REG_CMD && hostWdata == CMD_ACTIVE;

   // Wake-up sequencer
   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_page = page_ff;
      nxt_sum = sum_ff;
      nxt_phase = phase_ff;
      nxt_err = err_ff;
      nxt_holdCnt = holdCnt_ff;
      nxt_holdDone = holdDone_ff;
      nxt_eeStart = eeStart_ff;
      nxt_eeUsed = eeUsed_ff;
      nxt_done = done_ff;
      nxt_hdr = hdr_ff;
      nxt_spi = spi_ff;
      nxt_ref = ref_ff;
      nxt_eeDis = eeDis_ff;
      nxt_slvN = slvN_ff;
      nxt_ifCfg = ifCfg_ff;
      nxt_lock = lock_ff;
      nxt_slvEn = slvEn_ff;
      nxt_latch = latch_ff;
      volWe = 1'b0;
      volWa = cnt_ff;
      volWd = nvmData;
      liveWe = 1'b0;
      // GPIO hold timer runs from reset release
      if (!holdDone_ff)
      begin
         nxt_holdCnt = holdCnt_ff + HW'(1);
         nxt_holdDone = holdCnt_ff == HOLD_LAST;
      end
      if (hostOk && hostAddr == REG_PAGE)
         nxt_page = hostWdata;
      else if (hostOk && page_ff == PAGE_MASTER && hostAddr != REG_EESTAT
         && hostAddr != REG_CMD)
      begin
         volWe = 1'b1;
         volWa = hostAddr;
         volWd = hostWdata;
      end
      unique case (state_ff)
         ST_LATCH:
         begin
            nxt_latch = gpioS2_ff;
            nxt_cnt = '0;
            nxt_state = ST_NVM;
         end
         ST_NVM:
         begin
            volWe = 1'b1;
            volWa = cnt_ff;
            volWd = nvmData;
            nxt_cnt = cnt_ff + 8'h01;
            if (cnt_ff == ADDR_LAST)
            begin
               nxt_cnt = '0;
               nxt_phase = PH_BOOT;
               nxt_state = ST_APPLY;
            end
         end
         ST_APPLY:
         begin
            liveWe = 1'b1;
            if (cnt_ff == REG_IFCFG)
               nxt_ifCfg = vol[cnt_ff];
            if (cnt_ff == REG_LOCK)
               nxt_lock = vol[cnt_ff];
            if (cnt_ff == REG_SLV_EN)
               nxt_slvEn = vol[cnt_ff];
            nxt_cnt = cnt_ff + 8'h01;
            if (cnt_ff == ADDR_LAST)
            begin
               nxt_cnt = '0;
               if (phase_ff == PH_BOOT)
                  nxt_state = ST_HOLD;
               else if (phase_ff == PH_EE)
                  nxt_state = ST_DECIDE;
               else
                  nxt_state = ST_PRG;
            end
         end
         ST_HOLD:
         begin
            // Latch decoding only when the NVM enables it
            nxt_eeDis = lock_ff[LOCK_LATCH_EN_BIT]
               && latch_ff[GPIO_EEDIS];
            nxt_spi = !pinS2_ff;
            if (holdDone_ff)
            begin
               if (ifCfg_ff[IFCFG_EE_BIT] && pinS2_ff
                  && !nxt_eeDis)
               begin
                  nxt_eeUsed = 1'b1;
                  nxt_eeStart = 1'b1;
                  nxt_hdr = 1'b0;
                  nxt_sum = '0;
                  nxt_state = ST_EE;
               end
               else
                  nxt_state = ST_DECIDE;
            end
         end
         ST_EE:
         begin
            if (wordNew)
            begin
               if (wNone_ff)
               begin
                  nxt_err = ERR_NOBLOCK;
                  nxt_done = 1'b1;
                  nxt_spi = 1'b0;
                  nxt_eeStart = 1'b0;
                  nxt_state = ST_PRG;
               end
               else if (!hdr_ff)
               begin
                  nxt_hdr = 1'b1;
                  if (wData_ff != EE_HEADER)
                  begin
                     nxt_err = ERR_HEADER;
                     nxt_done = 1'b1;
                     nxt_spi = 1'b0;
                     nxt_eeStart = 1'b0;
                     nxt_state = ST_PRG;
                  end
               end
               else if (wLast_ff)
               begin
                  nxt_done = 1'b1;
                  nxt_eeStart = 1'b0;
                  if (wData_ff == sum_ff)
                  begin
                     nxt_spi = vol[REG_PORTCFG][PORTCFG_SPI_BIT];
                     nxt_phase = PH_EE;
                     nxt_cnt = '0;
                     nxt_state = ST_APPLY;
                  end
                  else
                  begin
                     nxt_err = ERR_CRC;
                     nxt_spi = 1'b0;
                     nxt_state = ST_PRG;
                  end
               end
               else
               begin
                  volWe = 1'b1;
                  volWa = wAddr_ff;
                  volWd = wData_ff;
                  nxt_sum = sum_ff ^ wData_ff;
               end
            end
         end
         ST_DECIDE:
            if (isLocked(lock_ff))
               nxt_state = ST_REF;
            else
               nxt_state = ST_PRG;
         ST_REF:
         begin
            nxt_ref = 1'b1;
            nxt_cnt = '0;
            nxt_state = ST_WAKE;
         end
         ST_WAKE:
         begin
            if (slvEn_ff[cnt_ff[2:0]])
               nxt_slvN[cnt_ff[2:0]] = 1'b1;
            nxt_cnt = cnt_ff + 8'h01;
            if (cnt_ff == SLV_LAST)
               nxt_state = ST_ACTIVE;
         end
         ST_ACTIVE:
            nxt_state = ST_ACTIVE;
         ST_PRG:
            if (cmdApply)
            begin
               nxt_phase = PH_PRG;
               nxt_cnt = '0;
               nxt_state = ST_APPLY;
            end
            else if (cmdActive)
               nxt_state = ST_REF;
      endcase
      nxt_rdata = '0;
      if (hostAddr == REG_PAGE)
         nxt_rdata = page_ff;
      else if (page_ff == PAGE_MASTER && hostAddr == REG_EESTAT)
         nxt_rdata = {5'h00, err_ff, done_ff};
      else if (page_ff == PAGE_MASTER)
         nxt_rdata = vol[hostAddr];
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_ff <= ST_LATCH;
         cnt_ff <= '0;
         page_ff <= PAGE_MASTER;
         sum_ff <= '0;
         phase_ff <= PH_BOOT;
         err_ff <= ERR_NONE;
         holdCnt_ff <= '0;
         holdDone_ff <= 1'b0;
         eeStart_ff <= 1'b0;
         eeUsed_ff <= 1'b0;
         done_ff <= 1'b0;
         hdr_ff <= 1'b0;
         spi_ff <= 1'b0;
         ref_ff <= 1'b0;
         eeDis_ff <= 1'b0;
         slvN_ff <= '0;
         ifCfg_ff <= '0;
         lock_ff <= '0;
         slvEn_ff <= '0;
         latch_ff <= '0;
         rdata_ff <= '0;
         reqSeen_ff <= 1'b0;
         ackTgl_ff <= 1'b0;
      end
      else if (ce)
      begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         page_ff <= nxt_page;
         sum_ff <= nxt_sum;
         phase_ff <= nxt_phase;
         err_ff <= nxt_err;
         holdCnt_ff <= nxt_holdCnt;
         holdDone_ff <= nxt_holdDone;
         eeStart_ff <= nxt_eeStart;
         eeUsed_ff <= nxt_eeUsed;
         done_ff <= nxt_done;
         hdr_ff <= nxt_hdr;
         spi_ff <= nxt_spi;
         ref_ff <= nxt_ref;
         eeDis_ff <= nxt_eeDis;
         slvN_ff <= nxt_slvN;
         ifCfg_ff <= nxt_ifCfg;
         lock_ff <= nxt_lock;
         slvEn_ff <= nxt_slvEn;
         latch_ff <= nxt_latch;
         rdata_ff <= nxt_rdata;
         reqSeen_ff <= reqS2_ff;
         ackTgl_ff <= reqSeen_ff;
      end
   end

   // Volatile copy and live settings
   always_ff @(posedge clk)
   begin
      if (ce && volWe)
         vol[volWa] <= volWd;
      if (ce && liveWe)
         live[cnt_ff] <= vol[cnt_ff];
      if (ce)
         liveData <= live[liveAddr];
   end

   assign nvmAddr = cnt_ff;
   assign hostRdata = rdata_ff;
   assign hostSpiMode = spi_ff;
   assign spiThreeWire = ifCfg_ff[IFCFG_SPI3W_BIT];
   assign i2cAddrA2 = ifCfg_ff[IFCFG_A2_BIT];
   assign slaveRstN = slvN_ff;
   assign refClkEn = ref_ff;
   assign chipActive = state_ff == ST_ACTIVE;
   assign prgCmdWait = state_ff == ST_PRG;
   assign eeReadDone = done_ff;
   assign eeError = err_ff;
   assign gpioLatched = latch_ff;

   // GPIO roles after the hold time
   logic [NUM_GPIO-1:0] nxt_gOut, nxt_gOe, gOut_ff, gOe_ff;
   logic [7:0] nxt_ins, ins_ff;
   always_comb
   begin
      nxt_gOut = '0;
      nxt_gOe = '0;
      nxt_ins = ins_ff;
      if (holdDone_ff)
      begin
         nxt_gOe = GPIO_OUT_MASK;
         nxt_gOut[GPIO_LLA] = pllLockLossN[0];
         nxt_gOut[GPIO_LLB] = pllLockLossN[1];
         nxt_gOut[GPIO_LLC] = pllLockLossN[2];
         nxt_gOut[GPIO_LLD] = pllLockLossN[3];
         nxt_gOut[GPIO_XOL] = oscClockLossN;
         if (eeUsed_ff)
         begin
            nxt_gOe[GPIO_RDDONE] = 1'b1;
            nxt_gOut[GPIO_RDDONE] = done_ff;
            nxt_gOe[GPIO_EEERR] = 1'b1;
            nxt_gOut[GPIO_EEERR] = done_ff && err_ff != ERR_NONE;
         end
         nxt_ins = {gpioS2_ff[GPIO_ODIS], gpioS2_ff[GPIO_SEL1],
            gpioS2_ff[GPIO_SEL0], gpioS2_ff[GPIO_FSA], gpioS2_ff[GPIO_FSB],
            gpioS2_ff[GPIO_EEDIS:GPIO_GP0]};
         if (eeUsed_ff)
            nxt_ins[1:0] = 2'h0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         gOut_ff <= '0;
         gOe_ff <= '0;
         ins_ff <= 8'h80;
      end
      else if (ce)
      begin
         gOut_ff <= nxt_gOut;
         gOe_ff <= nxt_gOe;
         ins_ff <= nxt_ins;
      end
   end

   assign gpioOut = gOut_ff;
   assign gpioOe = gOe_ff;
   assign outputDisableN = ins_ff[7];
   assign loopChoice = ins_ff[6:5];
   assign freqStepA = ins_ff[4];
   assign freqStepB = ins_ff[3];
   assign gpInput = ins_ff[2:0];

   // EEPROM link domain: one word held until the master acknowledges
   always_ff @(posedge eeClk)
   begin
      lrstS1_ff <= rst;
      linkRst_ff <= lrstS1_ff;
      startS1_ff <= eeStart_ff;
      startS2_ff <= startS1_ff;
      ackS1_ff <= ackTgl_ff;
      ackS2_ff <= ackS1_ff;
   end

   always_comb
   begin
      nxt_reqTgl = reqTgl_ff;
      nxt_wAddr = wAddr_ff;
      nxt_wData = wData_ff;
      nxt_wLast = wLast_ff;
      nxt_wNone = wNone_ff;
      if (eeValid && eeReady)
      begin
         nxt_reqTgl = !reqTgl_ff;
         nxt_wAddr = eeAddr;
         nxt_wData = eeData;
         nxt_wLast = eeLast;
         nxt_wNone = eeNoBlock;
      end
   end

   always_ff @(posedge eeClk)
   begin
      if (linkRst_ff)
      begin
         reqTgl_ff <= 1'b0;
         busy_ff <= 1'b0;
         wAddr_ff <= '0;
         wData_ff <= '0;
         wLast_ff <= 1'b0;
         wNone_ff <= 1'b0;
      end
      else
      begin
         reqTgl_ff <= nxt_reqTgl;
         busy_ff <= nxt_reqTgl != ackS2_ff;
         wAddr_ff <= nxt_wAddr;
         wData_ff <= nxt_wData;
         wLast_ff <= nxt_wLast;
         wNone_ff <= nxt_wNone;
      end
   end

   assign eeReady = startS2_ff && !busy_ff && reqTgl_ff == ackS2_ff;
   assign eeSearch = startS2_ff;

   sequence s_ee_fail;
      state_ff == ST_EE ##1 state_ff == ST_PRG;
   endsequence

   property p_slaves_held;
      @(posedge clk) disable iff (rst)
      state_ff inside {ST_NVM, ST_APPLY, ST_HOLD, ST_EE} && !ref_ff
         |-> slaveRstN == '0;
   endproperty
   a_slaves_held: assert property (p_slaves_held)
      else $error("slave released before wake-up");

   property p_hold_inputs;
      @(posedge clk) disable iff (rst)
      !holdDone_ff |-> gpioOe == '0;
   endproperty
   a_hold_inputs: assert property (p_hold_inputs)
      else $error("GPIO driven during hold");

   property p_locked_wake;
      @(posedge clk) disable iff (rst)
      state_ff == ST_DECIDE && ce && isLocked(lock_ff)
         |=> state_ff == ST_REF ##1 refClkEn;
   endproperty
   a_locked_wake: assert property (p_locked_wake)
      else $error("locked config did not wake");

   property p_unlocked_wait;
      @(posedge clk) disable iff (rst)
      state_ff == ST_DECIDE && ce && !isLocked(lock_ff)
         |=> prgCmdWait;
   endproperty
   a_unlocked_wait: assert property (p_unlocked_wait)
      else $error("unlocked config left command wait");

   property p_ref_first;
      @(posedge clk) disable iff (rst)
      slaveRstN != '0 |-> refClkEn;
   endproperty
   a_ref_first: assert property (p_ref_first)
      else $error("slave woken before reference paths");

   property p_ee_fail;
      @(posedge clk) disable iff (rst)
      s_ee_fail |-> eeReadDone && eeError != ERR_NONE && !hostSpiMode;
   endproperty
   a_ee_fail: assert property (p_ee_fail)
      else $error("EEPROM failure not reported");

   property p_page_sel;
      @(posedge clk) disable iff (rst)
      ce && hostOk && hostAddr == REG_PAGE |=> page_ff == $past(hostWdata);
   endproperty
   a_page_sel: assert property (p_page_sel)
      else $error("page register not written");

   property p_done_gpio;
      @(posedge clk) disable iff (rst)
      ce && holdDone_ff && eeUsed_ff && done_ff
         |=> gpioOe[GPIO_RDDONE] && gpioOut[GPIO_RDDONE];
   endproperty
   a_done_gpio: assert property (p_done_gpio)
      else $error("read-done not on GPIO");

   property p_link_take;
      @(posedge eeClk) disable iff (linkRst_ff)
      eeValid && eeReady |=> !eeReady;
   endproperty
   a_link_take: assert property (p_link_take)
      else $error("link accepted a second word early");
endmodule : mwcl_master_wakeup

// >>> hw/mwcl_pkg.sv
// Constants, register map and types of the master wake-up loader
package mwcl_pkg;
   localparam int DATA_W = 8;
   localparam int NUM_GPIO = 13;
   localparam int NUM_SLAVES = 7;
   // Page 0 register offsets
   localparam logic [7:0] REG_PAGE = 8'hFF;
   localparam logic [7:0] REG_IFCFG = 8'h33;
   localparam logic [7:0] REG_LOCK = 8'h30;
   localparam logic [7:0] REG_SLV_EN = 8'h31;
   localparam logic [7:0] REG_PORTCFG = 8'h34;
   localparam logic [7:0] REG_CMD = 8'h35;
   localparam logic [7:0] REG_EESTAT = 8'h36;
   localparam logic [7:0] PAGE_MASTER = 8'h00;
   localparam logic [7:0] ADDR_LAST = 8'hFE;
   localparam logic [7:0] SLV_LAST = 8'h06;
   // Field positions
   localparam int IFCFG_EE_BIT = 4;
   localparam int IFCFG_SPI3W_BIT = 5;
   localparam int IFCFG_A2_BIT = 6;
   localparam int LOCK_MANUAL_N_BIT = 2;
   localparam int LOCK_LATCH_EN_BIT = 3;
   localparam int PORTCFG_SPI_BIT = 0;
   localparam logic [1:0] LOCK_PAT_A = 2'h2;
   localparam logic [1:0] LOCK_PAT_B = 2'h1;
   // Configuration block header, value arbitrary
   localparam logic [7:0] EE_HEADER = 8'hA5;
   // Directives accepted in the program command wait state
   localparam logic [7:0] CMD_APPLY = 8'h01;
   localparam logic [7:0] CMD_ACTIVE = 8'h02;
   // EEPROM error codes
   localparam logic [1:0] ERR_NONE = 2'h0;
   localparam logic [1:0] ERR_HEADER = 2'h1;
   localparam logic [1:0] ERR_CRC = 2'h2;
   localparam logic [1:0] ERR_NOBLOCK = 2'h3;
   // Return points of the settings copy
   localparam logic [1:0] PH_BOOT = 2'h0;
   localparam logic [1:0] PH_EE = 2'h1;
   localparam logic [1:0] PH_PRG = 2'h2;
   // GPIO roles
   localparam int GPIO_LLA = 0;
   localparam int GPIO_LLB = 1;
   localparam int GPIO_LLC = 2;
   localparam int GPIO_ODIS = 3;
   localparam int GPIO_XOL = 4;
   localparam int GPIO_SEL0 = 5;
   localparam int GPIO_SEL1 = 6;
   localparam int GPIO_FSA = 7;
   localparam int GPIO_LLD = 8;
   localparam int GPIO_FSB = 9;
   localparam int GPIO_GP0 = 10;
   localparam int GPIO_RDDONE = 10;
   localparam int GPIO_EEERR = 11;
   localparam int GPIO_EEDIS = 12;
   localparam logic [12:0] GPIO_OUT_MASK = 13'h0117;
   // Timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int HOLD_TIME_NS = 1000000;
   localparam int HOLD_CYCLES = HOLD_TIME_NS / CLK_PERIOD_NS;

   typedef enum logic [3:0] {
      ST_LATCH, ST_NVM, ST_APPLY, ST_HOLD, ST_EE, ST_DECIDE,
      ST_REF, ST_WAKE, ST_ACTIVE, ST_PRG
   } mwcl_state_type;
endpackage : mwcl_pkg

// >>> test/mwcl_ee_model.sv
// EEPROM reader model on the link side
`timescale 1ns/1ps
module mwcl_ee_model
   import mwcl_pkg::*;
   (
   // Link
   input wire logic eeClk,
   input wire logic eeSearch,
   input wire logic eeReady,
   input wire logic [1:0] mode,
   output logic eeValid,
   output logic [7:0] eeAddr,
   output logic [7:0] eeData,
   output logic eeLast,
   output logic eeNoBlock
   );
   logic sent;
   task automatic put(input logic [7:0] a, input logic [7:0] d,
      input logic l, input logic nb);
      logic r;
      @(posedge eeClk);
      #1;
      {eeAddr, eeData, eeLast, eeNoBlock, eeValid} = {a, d, l, nb, 1'b1};
      do
      begin
         @(negedge eeClk) r = eeReady;
         @(posedge eeClk);
      end
      while (!r && eeSearch === 1'b1);
      #1 {eeValid, eeData, eeAddr} = {1'b0, ~d, ~a};
   endtask : put
   initial
   begin
      {eeValid, eeLast, eeNoBlock, eeAddr, eeData, sent} = '0;
      forever
      begin
         @(posedge eeClk);
         #1;
         if (eeSearch !== 1'b1)
            sent = 1'b0;
         else if (!sent)
         begin
            sent = 1'b1;
            put(8'h00, EE_HEADER, 1'b0, 1'b0);
            put(8'h31, 8'h7F, 1'b0, mode == 2'h2);
            put(8'h00, (mode == 2'h1) ? 8'h00 : 8'h7F, 1'b1, 1'b0);
         end
      end
   end
endmodule : mwcl_ee_model

// >>> test/tb_mwcl_master_wakeup.sv
// Self-checking bench of the master wake-up controller
`timescale 1ns/1ps
module tb_mwcl_master_wakeup;
   import mwcl_pkg::*;
   logic clk, rst, ce, eeClk, hostWr, pin, eeValid, eeLast, eeNoBlock;
   logic eeReady, eeSearch, hostBusy, hostSpiMode, spiThreeWire, i2cAddrA2;
   logic refClkEn, chipActive, prgCmdWait, eeReadDone, oscClockLossN;
   logic [1:0] eeError, mode;
   logic [2:0] flags;
   logic [3:0] pllLockLossN;
   logic [7:0] nvmAddr, nvmData, hostAddr, hostWdata, hostRdata, liveAddr;
   logic [7:0] liveData, eeAddr, eeData;
   logic [NUM_GPIO-1:0] gpioIn, gpioOe;
   logic [NUM_SLAVES-1:0] slaveRstN;
   logic [7:0] nvm [256];
   int bad_count = 0;
   int n_compared = 0;
   assign nvmData = nvm[nvmAddr];
   assign flags = {chipActive, prgCmdWait, eeReadDone};
   mwcl_master_wakeup #(.HOLD_CYC(20)) i_mwcl_master_wakeup (.clk, .rst,
      .ce, .nvmAddr, .nvmData, .hostWr, .hostAddr, .hostWdata, .hostRdata,
      .hostBusy, .hostPortSelectPin(pin), .hostSpiMode, .spiThreeWire,
      .i2cAddrA2, .liveAddr, .liveData, .eeClk, .eeValid, .eeAddr, .eeData,
      .eeLast, .eeNoBlock, .eeReady, .eeSearch, .gpioIn, .gpioOut(), .gpioOe,
      .pllLockLossN, .oscClockLossN, .outputDisableN(), .loopChoice(),
      .freqStepA(), .freqStepB(), .gpInput(), .gpioLatched(), .slaveRstN,
      .refClkEn, .chipActive, .prgCmdWait, .eeReadDone, .eeError);
   mwcl_ee_model i_mwcl_ee_model (.eeClk, .eeSearch, .eeReady, .mode,
      .eeValid, .eeAddr, .eeData, .eeLast, .eeNoBlock);
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial
   begin
      eeClk = 1'b0;
      #1.3;
      forever #3 eeClk = ~eeClk;
   end
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic hold_for(input int w, input int n);
      int k;
      k = 0;
      while (flags[w] !== 1'b1 && k < n)
      begin
         cyc(1);
         k++;
      end
      if (flags[w] !== 1'b1)
      begin
         bad_count++;
         close_out();
      end
   endtask : hold_for
   task automatic boot(input logic [7:0] lk, input logic [7:0] cf,
      input logic [7:0] en, input logic p);
      foreach (nvm[i])
         nvm[i] = 8'h00;
      {nvm[REG_LOCK], nvm[REG_IFCFG], nvm[REG_SLV_EN]} = {lk, cf, en};
      {pin, rst} = {p, 1'b1};
      cyc(4);
      chk(slaveRstN, 16'h0000);
      chk(gpioOe, 16'h0000);
      rst = 1'b0;
   endtask : boot
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      {hostAddr, liveAddr} = {a, a};
      cyc(2);
      chk(hostRdata, e);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      {hostWr, hostAddr, hostWdata} = {1'b1, a, d};
      cyc(1);
      hostWr = 1'b0;
      cyc(1);
   endtask : wr
   task automatic t_ee_ok();
      mode = 2'h0;
      boot(8'h00, 8'h50, 8'h00, 1'b1);
      nvm[REG_PORTCFG] = 8'h01;
      hold_for(0, 3000);
      chk(eeError, ERR_NONE);
      chk(hostSpiMode, 1'b1);
      hold_for(1, 1000);
      chk(i2cAddrA2, 1'b1);
      rd(REG_PAGE, PAGE_MASTER);
      wr(REG_PAGE, 8'h02);
      rd(REG_PAGE, 8'h02);
      rd(REG_SLV_EN, 8'h00);
      wr(REG_PAGE, PAGE_MASTER);
      rd(REG_SLV_EN, 8'h7F);
      chk(liveData, 16'h007F);
      wr(REG_CMD, CMD_ACTIVE);
      hold_for(2, 100);
      chk({refClkEn, slaveRstN}, 16'h00FF);
      $display("test ee_ok done");
   endtask : t_ee_ok
   task automatic t_fail(input logic [1:0] m, input logic [1:0] e);
      mode = m;
      boot(8'h00, 8'h50, 8'h05, 1'b1);
      hold_for(0, 3000);
      cyc(2);
      chk(eeError, e);
      chk(hostSpiMode, 1'b0);
      hold_for(1, 1000);
      rd(REG_EESTAT, {5'h00, e, 1'b1});
      rd(REG_SLV_EN, (m == 2'h1) ? 8'h7F : 8'h05);
      chk(liveData, 16'h0005);
      wr(REG_SLV_EN, 8'h06);
      wr(REG_CMD, CMD_APPLY);
      hold_for(1, 1000);
      rd(REG_SLV_EN, 8'h06);
      chk(liveData, 16'h0006);
      $display("test fail done");
   endtask : t_fail
   task automatic t_auto(input logic [7:0] lk);
      boot(lk, 8'h30, 8'h03, 1'b0);
      hold_for(2, 2000);
      chk(slaveRstN, 16'h0003);
      chk(spiThreeWire, 1'b1);
      chk(hostSpiMode, 1'b1);
      chk(eeReadDone, 1'b0);
      chk(gpioOe, GPIO_OUT_MASK);
      $display("test auto done");
   endtask : t_auto
   initial
   begin
      {rst, ce, hostWr, pin, mode, oscClockLossN} = 7'h61;
      {hostAddr, hostWdata, liveAddr, gpioIn} = '0;
      pllLockLossN = 4'hF;
      t_ee_ok();
      t_auto({5'h00, 1'b1, LOCK_PAT_A});
      t_auto({5'h00, 1'b1, LOCK_PAT_B});
      t_fail(2'h1, ERR_CRC);
      t_fail(2'h2, ERR_NOBLOCK);
      close_out();
   end
endmodule : tb_mwcl_master_wakeup
